// ===== core/tdm_switch_host_port.sv
// Function
// - Eight-bit data, six address, four control lines.
// - Control and connection banks read-write, data read-only.
// - Host memory access waits for serial sequencer.
// - Connection memory access acknowledged within 800 ns.
// - Data memory access acknowledged within 1220 ns.
// - A5,A1,A0 low selects control register.
// - A5 high: low bits pick one channel.
// - Bank select picks data, conn low, high.
// - Stream page picks the 32-location subsection.
// - Split access: reads data, writes conn low.
// - Without split, bank select steers accesses.
// - Global force acts as message and enable.
// - Message bit picks low byte or address.
// - Drive pin low tristates all eight serial stream outputs.
// - Drive pin high: per-channel enable bit rules.
// - High bank bit 1 sent serially, 256/frame.
// - Control serial bit follows stored bit level.
// - Control bits lead their channel by one.
// - Stream order interleaves inside each channel time.
// - Per-channel delay mode bit chooses delay type.
// - Delay bit six: low variable, high constant.
// - Message outputs low byte, else addressed data.
`include "tdm_switch_defines.svh"

module tdm_switch_host_port (
	input wire logic clk,
	input wire logic srst,
	input wire logic host_cs_n,
	input wire logic host_ds,
	input wire logic host_rw,
	input wire logic [5:0] host_addr_lines,
	input wire logic [7:0] host_data_bus_in,
	output logic [7:0] host_data_bus_out,
	output logic host_data_bus_oe_n,
	output logic xfer_ack_n_out,
	output logic xfer_ack_n_oe_n,
	input wire logic c4_clk_pin,
	input wire logic frame_pulse_n,
	input wire logic global_drive_en,
	input wire logic cap_wr_en,
	input wire logic [7:0] cap_wr_addr,
	input wire logic [7:0] cap_wr_data,
	output logic [7:0] ser_out,
	output logic [7:0] ser_oe_n,
	output logic ctrl_serial_out,
	output logic [7:0] delay_mode_const
);

	// ****************************************************************
	// Constants and state
	// ****************************************************************
	localparam int ACK_CM_CYC = `ACK_CM_MAX_CYC - `ACK_PIPE_CYC;
	localparam int ACK_DM_CYC = `ACK_DM_MAX_CYC - `ACK_PIPE_CYC;

	tdm_switch_pkg::port_state_s s;
	tdm_switch_pkg::port_state_s n;
	tdm_switch_pkg::pins_s pins_now;
	tdm_switch_pkg::bank_e dec_tgt;

	logic qual;
	logic start;
	logic c4_rise;
	logic host_go;
	logic [2:0] p;
	logic [2:0] stream;
	logic [1:0] phase;
	logic [8:0] cnt_n;
	logic [7:0] cm_addr;
	logic [7:0] dm_addr;
	logic cml_we;
	logic cmh_we;
	logic [7:0] cml_rd;
	logic [7:0] cmh_rd;
	logic [7:0] dm_rd;
	logic [7:0][7:0] tick_byte;
	logic [7:0] tick_oe;
	logic [7:0] tick_cst;
	logic [7:0] tick_dly;

	// ****************************************************************
	// Decode and arbitration
	// ****************************************************************
	assign pins_now = {host_cs_n, host_ds, host_rw, host_addr_lines, host_data_bus_in,
		c4_clk_pin, frame_pulse_n, global_drive_en};
	assign qual = !s.s2.cs_n && s.s2.ds;
	assign c4_rise = s.s2.c4 && !s.c4_prev;
	assign cnt_n = (!s.s2.fp_n) ? 9'h000 : s.cnt + 9'h001;
	assign p = s.cnt[3:1];
	assign start = s.bit_tick && (p == 3'h0);
	assign stream = s.step[3:1];
	assign phase = s.step[5:4];
	assign dec_tgt = s.ctrl.split_access ?
		(s.rw ? tdm_switch_pkg::BANK_DATA : tdm_switch_pkg::BANK_CONN_LOW) :
		s.ctrl.bank_select;
	assign host_go = (s.hst == tdm_switch_pkg::H_ISSUE) && !s.seq_busy && !start;
	assign cm_addr = s.seq_busy ?
		{stream, (phase == 2'h2) ? s.pf_chan + 5'h01 : s.pf_chan} :
		{s.ctrl.stream_page, s.addr[4:0]};
	assign dm_addr = s.seq_busy ? s.cml_hold[stream] : {s.ctrl.stream_page, s.addr[4:0]};
	assign cml_we = host_go && !s.rw && (s.tgt == tdm_switch_pkg::BANK_CONN_LOW);
	assign cmh_we = host_go && !s.rw && (s.tgt == tdm_switch_pkg::BANK_CONN_HIGH);
	assign tick_byte = (p == 3'h0) ? s.nxt_byte : s.cur_byte;
	assign tick_oe = (p == 3'h0) ? s.nxt_oe : s.cur_oe;
	assign tick_cst = (p == 3'h0) ? s.nxt_cst : s.cur_cst;
	assign tick_dly = (p == 3'h0) ? s.nxt_dly : s.cur_dly;

	// ****************************************************************
	// Memories
	// ****************************************************************
	tdm_chan_mem #(.WIDTH(8), .ADDR_W(8)) u_conn_low (
		.clk(clk),
		.wr_en(cml_we),
		.wr_addr(cm_addr),
		.wr_data(s.wdata),
		.rd_addr(cm_addr),
		.rd_data(cml_rd)
	);

	tdm_chan_mem #(.WIDTH(8), .ADDR_W(8)) u_conn_high (
		.clk(clk),
		.wr_en(cmh_we),
		.wr_addr(cm_addr),
		.wr_data(s.wdata),
		.rd_addr(cm_addr),
		.rd_data(cmh_rd)
	);

	// The host has no write path here; only the capture side fills it.
	tdm_chan_mem #(.WIDTH(8), .ADDR_W(8)) u_data_mem (
		.clk(clk),
		.wr_en(cap_wr_en),
		.wr_addr(cap_wr_addr),
		.wr_data(cap_wr_data),
		.rd_addr(dm_addr),
		.rd_data(dm_rd)
	);

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		n = s;
		n.s1 = pins_now;
		n.s2 = s.s1;
		n.c4_prev = s.s2.c4;
		n.bit_tick = 1'b0;
		if (c4_rise) begin
			n.cnt = cnt_n;
			n.bit_tick = !cnt_n[0];
		end

		// Host access sequence.
		case (s.hst)
			tdm_switch_pkg::H_IDLE: begin
				if (qual) begin
					n.addr = s.s2.addr;
					n.rw = s.s2.rw;
					n.wdata = s.s2.data;
					n.hst = tdm_switch_pkg::H_DECODE;
				end
			end
			tdm_switch_pkg::H_DECODE: begin
				n.tgt = dec_tgt;
				n.rdata_out = 8'h00;
				n.hst = tdm_switch_pkg::H_ACK;
				if (!s.addr[`ADDR_MEM_BIT]) begin
					if (s.addr[1:0] == `SWITCH_CTRL_OFFSET) begin
						if (s.rw) begin
							n.rdata_out = s.ctrl;
						end else begin
							n.ctrl = s.wdata;
						end
					end
				end else if (dec_tgt == tdm_switch_pkg::BANK_NONE) begin
					n.hst = tdm_switch_pkg::H_ACK;
				end else if ((dec_tgt == tdm_switch_pkg::BANK_DATA) && !s.rw) begin
					n.hst = tdm_switch_pkg::H_ACK;
				end else begin
					n.hst = tdm_switch_pkg::H_ISSUE;
				end
			end
			tdm_switch_pkg::H_ISSUE: begin
				if (host_go) begin
					n.hst = s.rw ? tdm_switch_pkg::H_CAPTURE : tdm_switch_pkg::H_ACK;
				end
			end
			tdm_switch_pkg::H_CAPTURE: begin
				case (s.tgt)
					tdm_switch_pkg::BANK_DATA: n.rdata_out = dm_rd;
					tdm_switch_pkg::BANK_CONN_LOW: n.rdata_out = cml_rd;
					default: n.rdata_out = cmh_rd;
				endcase
				n.hst = tdm_switch_pkg::H_ACK;
			end
			tdm_switch_pkg::H_ACK: begin
				n.ack = 1'b1;
				n.drive = s.rw;
				if (!qual) begin
					n.ack = 1'b0;
					n.drive = 1'b0;
					n.hst = tdm_switch_pkg::H_IDLE;
				end
			end
			default: begin
				n.hst = tdm_switch_pkg::H_IDLE;
			end
		endcase

		// Serial prefetch: next channel's data and the control bits one channel further on.
		if (start) begin
			n.cur_byte = s.nxt_byte;
			n.cur_oe = s.nxt_oe;
			n.cur_cst = s.nxt_cst;
			n.cur_dly = s.nxt_dly;
			n.seq_busy = 1'b1;
			n.step = 6'h00;
			n.pf_chan = s.cnt[8:4] + 5'h01;
		end else if (s.seq_busy) begin
			if (s.step[0]) begin
				case (phase)
					2'h0: begin
						n.cml_hold[stream] = cml_rd;
						n.msg_hold[stream] = s.ctrl.global_msg_force ||
							cmh_rd[`CMH_MSG_BIT];
						n.nxt_oe[stream] = s.ctrl.global_msg_force ||
							cmh_rd[`CMH_OE_BIT];
						n.nxt_dly[stream] = cmh_rd[`CMH_DELAY_BIT];
					end
					2'h1: begin
						n.nxt_byte[stream] = s.msg_hold[stream] ? s.cml_hold[stream] : dm_rd;
					end
					default: begin
						n.nxt_cst[stream] = cmh_rd[`CMH_CST_BIT];
					end
				endcase
				if (s.step == `SEQ_LAST_STEP) begin
					n.seq_busy = 1'b0;
				end
			end
			n.step = s.step + 6'h01;
		end

		// Bit boundary: one bit per stream, one control bit per stream in turn.
		if (s.bit_tick) begin
			for (int st = 0; st < 8; st++) begin
				n.ser_out[st] = tick_byte[st][3'h7 - p];
			end
			n.live_oe = tick_oe;
			n.dly_out = tick_dly;
			n.cst_out = tick_cst[p];
		end
		n.ser_oe_n = ~(n.live_oe & {8{s.s2.drive_en}});
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			s <= '0;
			s.ser_oe_n <= 8'hFF;
			s.ctrl <= `CTRL_RESET;
		end else begin
			s <= n;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign host_data_bus_out = s.rdata_out;
	assign host_data_bus_oe_n = !s.drive;
	assign xfer_ack_n_out = s.ack_level;
	assign xfer_ack_n_oe_n = !s.ack;
	assign ser_out = s.ser_out;
	assign ser_oe_n = s.ser_oe_n;
	assign ctrl_serial_out = s.cst_out;
	assign delay_mode_const = s.dly_out;

	// ****************************************************************
	// Checks
	// ****************************************************************
	a_ack_conn_bound: assert property (@(posedge clk) disable iff (srst)
		(s.hst == tdm_switch_pkg::H_DECODE && s.addr[5] && dec_tgt[1])
		|-> ##[1:ACK_CM_CYC] s.ack)
		else $error("Connection memory acknowledge late.");

	a_ack_data_bound: assert property (@(posedge clk) disable iff (srst)
		(s.hst == tdm_switch_pkg::H_DECODE && s.addr[5] && dec_tgt == tdm_switch_pkg::BANK_DATA)
		|-> ##[1:ACK_DM_CYC] s.ack)
		else $error("Data memory acknowledge late.");

	a_data_readonly: assert property (@(posedge clk) disable iff (srst)
		(host_go && s.tgt == tdm_switch_pkg::BANK_DATA) |-> s.rw && !cml_we && !cmh_we)
		else $error("Host wrote the data memory.");

	a_ctrl_write: assert property (@(posedge clk) disable iff (srst)
		(s.hst == tdm_switch_pkg::H_DECODE && !s.addr[5] && s.addr[1:0] == 2'h0 && !s.rw)
		|=> (s.ctrl == $past(s.wdata)) ##1 s.ack)
		else $error("Control register write lost.");

	a_split_route: assert property (@(posedge clk) disable iff (srst)
		(s.hst == tdm_switch_pkg::H_DECODE && s.ctrl.split_access)
		|=> s.tgt == ($past(s.rw) ? tdm_switch_pkg::BANK_DATA : tdm_switch_pkg::BANK_CONN_LOW))
		else $error("Split access routed wrongly.");

	a_drive_off: assert property (@(posedge clk) disable iff (srst)
		(!s.s2.drive_en) |=> (s.ser_oe_n == 8'hFF))
		else $error("Serial output driven while drive pin low.");

	a_msg_source: assert property (@(posedge clk) disable iff (srst)
		(s.seq_busy && !start && s.step[0] && phase == 2'h1 && s.msg_hold[stream])
		|=> s.nxt_byte[$past(stream)] == $past(s.cml_hold[stream]))
		else $error("Message channel took the wrong byte.");

	a_bus_release: assert property (@(posedge clk) disable iff (srst)
		(!qual) |=> ##1 (!s.drive && !s.ack))
		else $error("Bus or acknowledge held after strobe end.");

	a_cst_lead: assert property (@(posedge clk) disable iff (srst)
		(start) |=> ##[1:4] (s.cst_out == s.cur_cst[0]))
		else $error("Control serial bit not from the leading channel.");

	a_host_wait: assert property (@(posedge clk) disable iff (srst)
		(s.hst == tdm_switch_pkg::H_ISSUE && (s.seq_busy || start))
		|=> (s.hst == tdm_switch_pkg::H_ISSUE) && !$past(cml_we) && !$past(cmh_we))
		else $error("Host access overtook the serial sequencer.");

	a_refused_ack: assert property (@(posedge clk) disable iff (srst)
		(s.hst == tdm_switch_pkg::H_DECODE && s.addr[5] && dec_tgt == tdm_switch_pkg::BANK_NONE)
		|=> (s.hst == tdm_switch_pkg::H_ACK) && (s.rdata_out == 8'h00))
		else $error("Unused bank access not refused.");

	a_force_enable: assert property (@(posedge clk) disable iff (srst)
		(s.seq_busy && !start && s.step[0] && phase == 2'h0 && s.ctrl.global_msg_force)
		|=> s.nxt_oe[$past(stream)] && s.msg_hold[$past(stream)])
		else $error("Global force did not set message and enable.");

	a_drive_read: assert property (@(posedge clk) disable iff (srst)
		(s.drive) |-> s.rw)
		else $error("Data bus driven outside a read.");

endmodule : tdm_switch_host_port

// ===== shared/tdm_switch_defines.svh
`ifndef TDM_SWITCH_DEFINES_SVH
`define TDM_SWITCH_DEFINES_SVH

// ****************************************************************
// Register map and field positions
// ****************************************************************
`define SWITCH_CTRL_OFFSET 6'h00
`define CTRL_RESET 8'h00
`define ADDR_MEM_BIT 5
`define CMH_OE_BIT 0
`define CMH_CST_BIT 1
`define CMH_MSG_BIT 2
`define CMH_DELAY_BIT 6

// ****************************************************************
// Timing
// ****************************************************************
`define CLK_PERIOD_NS 10
`define ACK_CM_MAX_NS 800
`define ACK_DM_MAX_NS 1220
`define ACK_CM_MAX_CYC (`ACK_CM_MAX_NS / `CLK_PERIOD_NS)
`define ACK_DM_MAX_CYC (`ACK_DM_MAX_NS / `CLK_PERIOD_NS)
`define ACK_PIPE_CYC 4
`define SEQ_LAST_STEP 6'h2F

`endif

// ===== shared/tdm_switch_pkg.sv
package tdm_switch_pkg;

	// ****************************************************************
	// Modes and states
	// ****************************************************************
	typedef enum logic [1:0] {
		BANK_NONE = 2'b00,
		BANK_DATA = 2'b01,
		BANK_CONN_LOW = 2'b10,
		BANK_CONN_HIGH = 2'b11
	} bank_e;

	typedef enum logic [2:0] {
		H_IDLE = 3'b000,
		H_DECODE = 3'b001,
		H_ISSUE = 3'b010,
		H_CAPTURE = 3'b011,
		H_ACK = 3'b100
	} host_e;

	// ****************************************************************
	// Carriers
	// ****************************************************************
	typedef struct packed {
		logic split_access;
		logic global_msg_force;
		logic spare;
		bank_e bank_select;
		logic [2:0] stream_page;
	} ctrl_s;

	typedef struct packed {
		logic cs_n;
		logic ds;
		logic rw;
		logic [5:0] addr;
		logic [7:0] data;
		logic c4;
		logic fp_n;
		logic drive_en;
	} pins_s;

	typedef struct packed {
		pins_s s1;
		pins_s s2;
		logic c4_prev;
		ctrl_s ctrl;
		host_e hst;
		logic [5:0] addr;
		logic rw;
		logic [7:0] wdata;
		bank_e tgt;
		logic [7:0] rdata_out;
		logic drive;
		logic ack;
		logic ack_level;
		logic [8:0] cnt;
		logic bit_tick;
		logic seq_busy;
		logic [5:0] step;
		logic [4:0] pf_chan;
		logic [7:0][7:0] cml_hold;
		logic [7:0][7:0] nxt_byte;
		logic [7:0][7:0] cur_byte;
		logic [7:0] msg_hold;
		logic [7:0] nxt_oe;
		logic [7:0] cur_oe;
		logic [7:0] nxt_cst;
		logic [7:0] cur_cst;
		logic [7:0] nxt_dly;
		logic [7:0] cur_dly;
		logic [7:0] live_oe;
		logic [7:0] ser_out;
		logic [7:0] ser_oe_n;
		logic [7:0] dly_out;
		logic cst_out;
	} port_state_s;

endpackage : tdm_switch_pkg

// ===== core/tdm_chan_mem.sv
module tdm_chan_mem #(
	parameter int WIDTH = 8,
	parameter int ADDR_W = 8
) (
	input wire logic clk,
	input wire logic wr_en,
	input wire logic [ADDR_W-1:0] wr_addr,
	input wire logic [WIDTH-1:0] wr_data,
	input wire logic [ADDR_W-1:0] rd_addr,
	output logic [WIDTH-1:0] rd_data
);

	// ****************************************************************
	// Storage
	// ****************************************************************
	// No reset: contents are undefined at power up, so the drive pin must keep outputs off.
	logic [WIDTH-1:0] mem [2**ADDR_W];

	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		rd_data <= mem[rd_addr];
	end

endmodule : tdm_chan_mem

// ===== testbench/host_cpu_model.sv
module host_cpu_model (
	input wire logic clk,
	output logic cs_n,
	output logic ds,
	output logic rw,
	output logic [5:0] addr,
	output logic [7:0] bus_level,
	input wire logic [7:0] dev_data,
	input wire logic dev_data_oe_n,
	input wire logic ack_out,
	input wire logic ack_oe_n
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [7:0] drv;
	logic ack_wire;

	// The acknowledge line has a pull-up, so it is high whenever released.
	assign ack_wire = ack_oe_n ? 1'b1 : ack_out;
	assign bus_level = !dev_data_oe_n ? dev_data : drv;

	initial begin
		cs_n = 1'b1;
		ds = 1'b0;
		rw = 1'b1;
		addr = 6'h00;
		drv = 8'h00;
	end

	// ****************************************************************
	// One qualified access
	// ****************************************************************
	task automatic access(input logic r, input logic [5:0] a, input logic [7:0] wd,
		output logic [7:0] rv, output int cyc);
		cyc = 0;
		@(negedge clk);
		cs_n = 1'b0;
		ds = 1'b1;
		rw = r;
		addr = a;
		if (!r) begin
			drv = wd;
		end
		do begin
			@(posedge clk);
			cyc++;
		end while (ack_wire !== 1'b0 && cyc < 400);
		rv = bus_level;
		@(negedge clk);
		ds = 1'b0;
		cs_n = 1'b1;
		// After a write, the released bus never keeps the written value.
		drv = ~drv;
		repeat (20) begin
			@(posedge clk);
			if (ack_wire === 1'b1) begin
				break;
			end
		end
	endtask : access
endmodule : host_cpu_model

// ===== testbench/testbench.sv
`include "tdm_switch_defines.svh"

module testbench;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int CM = `ACK_CM_MAX_CYC;
	localparam int DM = `ACK_DM_MAX_CYC;

	logic clk = 1'b0;
	logic srst = 1'b1;
	logic c4 = 1'b0;
	logic fp_n = 1'b1;
	logic drive_en = 1'b0;
	logic cap_en = 1'b0;
	logic [7:0] cap_addr = 8'h00;
	logic [7:0] cap_data = 8'h00;
	logic cs_n, ds, rw, d_oe_n, a_out, a_oe_n, cst;
	logic [5:0] addr;
	logic [7:0] bus, d_out, ser, ser_oe_n, dly;
	int n_fail = 0;
	int n_tests = 0;
	int hi, first, bad, dhi;
	logic [7:0] ch5;

	always #5 clk = ~clk;

	// ****************************************************************
	// Master clock and frame pulse
	// ****************************************************************
	// Master clock edges fall on the bench clock's falling edge, away from sampling.
	initial begin
		#10;
		forever begin
			for (int k = 0; k < 512; k++) begin
				c4 = 1'b0;
				fp_n = (k == 511) ? 1'b0 : 1'b1;
				#120;
				c4 = 1'b1;
				#120;
			end
		end
	end

	host_cpu_model host_u (.clk(clk), .cs_n(cs_n), .ds(ds), .rw(rw), .addr(addr),
		.bus_level(bus), .dev_data(d_out), .dev_data_oe_n(d_oe_n), .ack_out(a_out),
		.ack_oe_n(a_oe_n));

	tdm_switch_host_port dut_u (.clk(clk), .srst(srst), .host_cs_n(cs_n), .host_ds(ds),
		.host_rw(rw), .host_addr_lines(addr), .host_data_bus_in(bus),
		.host_data_bus_out(d_out), .host_data_bus_oe_n(d_oe_n), .xfer_ack_n_out(a_out),
		.xfer_ack_n_oe_n(a_oe_n), .c4_clk_pin(c4), .frame_pulse_n(fp_n),
		.global_drive_en(drive_en), .cap_wr_en(cap_en), .cap_wr_addr(cap_addr),
		.cap_wr_data(cap_data), .ser_out(ser), .ser_oe_n(ser_oe_n),
		.ctrl_serial_out(cst), .delay_mode_const(dly));

	task automatic final_report();
		$display("tests=%0d fails=%0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : final_report

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	// ****************************************************************
	// Bus cycles
	// ****************************************************************
	task automatic acc(input logic r, input logic [5:0] a, input logic [7:0] wd, input int lim,
		output logic [7:0] rv);
		int c;
		host_u.access(r, a, wd, rv, c);
		chk({7'h00, c <= lim}, 8'h01);
	endtask : acc

	task automatic wr(input logic [5:0] a, input logic [7:0] d, input int lim);
		logic [7:0] rv;
		acc(1'b0, a, d, lim, rv);
	endtask : wr

	task automatic rd(input logic [5:0] a, input logic [7:0] exp, input int lim);
		logic [7:0] rv;
		acc(1'b1, a, 8'h00, lim, rv);
		chk(rv, exp);
	endtask : rd

	// Scans one whole frame, starting at the frame pulse.
	task automatic frame_scan(input logic [7:0] oe_exp);
		hi = 0;
		first = -1;
		bad = 0;
		dhi = 0;
		ch5 = 8'h00;
		@(posedge c4 iff !fp_n);
		for (int i = 0; i < 12288; i++) begin
			@(posedge clk);
			if (ser_oe_n !== oe_exp) begin
				bad++;
			end
			// Middle of each bit of stream 2, channel 5.
			if (i >= 1948 && i < 2332 && (i - 1948) % 48 == 0) begin
				ch5 = {ch5[6:0], ser[2]};
			end
			if (dly === 8'h01) begin
				dhi++;
			end
			if (cst === 1'b1) begin
				if (first < 0) begin
					first = i;
				end
				hi++;
			end
		end
	endtask : frame_scan

	initial begin
		#1_000_000;
		n_fail++;
		final_report();
	end

	initial begin
		repeat (16) @(posedge clk);
		@(negedge clk);
		srst = 1'b0;
		chk({d_oe_n, a_oe_n, cst, 5'h00}, 8'hC0);
		chk(ser_oe_n, 8'hFF);
		rd(6'h00, 8'h00, CM);
		wr(6'h1C, 8'h12, CM);
		rd(6'h00, 8'h12, CM);
		wr(6'h25, 8'hA5, CM);
		rd(6'h25, 8'hA5, CM);
		wr(6'h00, 8'h1A, CM);
		wr(6'h25, 8'h47, CM);
		rd(6'h25, 8'h47, CM);
		for (int k = 0; k < 2; k++) begin
			@(negedge clk);
			cap_en = 1'b1;
			cap_addr = (k == 0) ? 8'h45 : 8'h66;
			cap_data = (k == 0) ? 8'h3C : 8'h5A;
		end
		@(negedge clk);
		cap_en = 1'b0;
		wr(6'h00, 8'h0A, CM);
		wr(6'h25, 8'hFF, DM);
		rd(6'h25, 8'h3C, DM);
		wr(6'h00, 8'h9A, CM);
		wr(6'h25, 8'h66, DM);
		rd(6'h25, 8'h3C, DM);
		wr(6'h00, 8'h12, CM);
		rd(6'h25, 8'hA5 ^ 8'hC3, CM);
		wr(6'h00, 8'h1A, CM);
		rd(6'h25, 8'h47, CM);
		// Every connection high word is written before the drivers may turn on.
		for (int p = 0; p < 8; p++) begin
			wr(6'h00, 8'h18 | 8'(p), CM);
			for (int c = 0; c < 32; c++) begin
				wr(6'h20 | 6'(c), (p == 0 && c == 0) ? 8'h42 : 8'h00, CM);
			end
		end
		@(negedge clk);
		drive_en = 1'b1;
		// Two channel times pass so that every prefetch follows the last write.
		repeat (800) @(posedge clk);
		frame_scan(8'hFF);
		chk(bad[7:0], 8'h00);
		chk(hi[7:0], 8'h30);
		chk({7'h00, first >= 11904 && first <= 11916}, 8'h01);
		chk(ch5, 8'h5A);
		chk({7'h00, dhi == 384}, 8'h01);
		wr(6'h00, 8'h40, CM);
		rd(6'h25, 8'h00, CM);
		repeat (800) @(posedge clk);
		frame_scan(8'h00);
		chk(bad[7:0], 8'h00);
		chk(ch5, 8'h66);
		@(negedge clk);
		drive_en = 1'b0;
		repeat (8) @(posedge clk);
		chk(ser_oe_n, 8'hFF);
		final_report();
	end
endmodule : testbench
